// ---- core/dcr_pkg.sv ----
// Package for the device capability register block.
// Assumes a single core clock domain and a plain register port.
package dcr_pkg;
   localparam logic [7:0]  DCR_OFS_DEVCAP      = 8'hb4;
   localparam int          DCR_MPS_LSB         = 0;
   localparam logic [2:0]  DCR_MPS_RST         = 3'h1;
   localparam int          DCR_PHANTOM_LSB     = 3;
   localparam logic [1:0]  DCR_PHANTOM_RST     = 2'h0;
   localparam int          DCR_TAG8_BIT        = 5;
   localparam logic        DCR_TAG8_RST        = 1'b1;
   localparam int          DCR_L0S_LSB         = 6;
   localparam logic [2:0]  DCR_L0S_RST         = 3'h0;
   localparam int          DCR_L1_LSB          = 9;
   localparam logic [2:0]  DCR_L1_RST          = 3'h0;
   localparam int          DCR_ATTN_BTN_BIT    = 12;
   localparam int          DCR_ATTN_IND_BIT    = 13;
   localparam int          DCR_PWR_IND_BIT     = 14;
   localparam int          DCR_SPL_VAL_LSB     = 18;
   localparam logic [7:0]  DCR_SPL_VAL_RST     = 8'h00;
   localparam int          DCR_SPL_SCL_LSB     = 26;
   localparam logic [1:0]  DCR_SPL_SCL_RST     = 2'h0;

   typedef struct packed {
      logic       valid;
      logic [1:0] scale;
      logic [7:0] value;
   } dcr_spl_msg_s;
endpackage

// ---- core/dcr_spl_capture.sv ----
// Holds the captured slot power limit value and scale.
// Assumes a message strobe from the link layer, one cycle per message.
`timescale 1ns/100ps
`default_nettype none
module dcr_spl_capture
   import dcr_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire dcr_spl_msg_s msg,
   output logic [7:0]        value_q,
   output logic [1:0]        scale_q
);
   logic [7:0] value_d;
   logic [1:0] scale_d;

   always_comb
   begin
      value_d = value_q;
      scale_d = scale_q;
      if (msg.valid)
      begin
         value_d = msg.value; // [R9]
         scale_d = msg.scale; // [R10]
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         value_q <= DCR_SPL_VAL_RST;
         scale_q <= DCR_SPL_SCL_RST;
      end
      else
      begin
         value_q <= value_d;
         scale_q <= scale_d;
      end
   end

   chk_spl_value_load : assert property (@(posedge clk) disable iff (!rst_b) // [R9]
      msg.valid |=> value_q == $past(msg.value))
      else $error("Slot power value not captured");
   chk_spl_scale_load : assert property (@(posedge clk) disable iff (!rst_b) // [R10]
      msg.valid |=> scale_q == $past(msg.scale))
      else $error("Slot power scale not captured");
   chk_spl_hold_idle : assert property (@(posedge clk) disable iff (!rst_b) // [R11]
      !msg.valid |=> $stable(value_q) && $stable(scale_q))
      else $error("Slot power fields changed without a message");
endmodule
`default_nettype wire

// ---- core/dcr_devcap.sv ----
// Device capability register, read over a plain register port.
// Assumes the hot-plug strap and bridge direction are stable after reset
// and that slot power messages arrive decoded as one-cycle strobes.
//
// Functional notes
// R1 - Bits 2:0 report the maximum payload size code, fixed at 256 bytes.
// R2 - Bits 4:3 read zero because no phantom functions are supported.
// R3 - Bit 5 reads one to advertise 8-bit tag support.
// R4 - Bits 8:6 report the acceptable L0s exit latency code, reading 000.
// R5 - Bits 11:9 report the acceptable L1 exit latency code, reading 000.
// R6 - Bit 12 reads one only when hot-plug is strapped on in forward mode.
// R7 - Bits 13 and 14 follow the hot-plug strap.
// R8 - Reserved bits 17:15 and 31:28 read zero.
// R9 - A slot power limit message loads its value into bits 25:18, zero after reset.
// R10 - A slot power limit message loads its scale into bits 27:26, zero after reset.
// R11 - The upstream partner must send that message for bits 27:18 to become nonzero.
`timescale 1ns/100ps
`default_nettype none
module dcr_devcap
   import dcr_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   input  wire logic        HOTPLUG_STRAP,
   input  wire logic        FORWARD_MODE,
   input  wire logic        SPL_VALID,
   input  wire logic [7:0]  SPL_VALUE,
   input  wire logic [1:0]  SPL_SCALE
);
   logic [31:0]  rdata_q;
   logic [31:0]  rdata_d;
   logic         hp_q;
   logic         hp_d;
   logic         fwd_q;
   logic         fwd_d;
   logic [7:0]   spl_value;
   logic [1:0]   spl_scale;
   logic [31:0]  devcap;
   dcr_spl_msg_s spl_msg;

   assign spl_msg = '{valid: SPL_VALID, scale: SPL_SCALE, value: SPL_VALUE};

   dcr_spl_capture u_spl
   (
      .clk     (CORE_CLK),
      .rst_b   (RST_B),
      .msg     (spl_msg),
      .value_q (spl_value),
      .scale_q (spl_scale)
   );

   // Strap levels are registered after reset release, never loaded under reset
   always_comb
   begin
      hp_d  = HOTPLUG_STRAP;
      fwd_d = FORWARD_MODE;
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         hp_q  <= 1'b0;
         fwd_q <= 1'b0;
      end
      else
      begin
         hp_q  <= hp_d;
         fwd_q <= fwd_d;
      end
   end

   // Register image; all bits read-only, writes ignored
   always_comb
   begin
      devcap = 32'h0000_0000; // [R8]
      devcap[DCR_MPS_LSB +: 3] = DCR_MPS_RST; // [R1]
      devcap[DCR_PHANTOM_LSB +: 2] = DCR_PHANTOM_RST; // [R2]
      devcap[DCR_TAG8_BIT] = DCR_TAG8_RST; // [R3]
      devcap[DCR_L0S_LSB +: 3] = DCR_L0S_RST; // [R4]
      devcap[DCR_L1_LSB +: 3] = DCR_L1_RST; // [R5]
      devcap[DCR_ATTN_BTN_BIT] = hp_q & fwd_q; // [R6]
      devcap[DCR_ATTN_IND_BIT] = hp_q; // [R7]
      devcap[DCR_PWR_IND_BIT] = hp_q; // [R7]
      devcap[DCR_SPL_VAL_LSB +: 8] = spl_value; // [R9]
      devcap[DCR_SPL_SCL_LSB +: 2] = spl_scale; // [R10]
   end

   // Read data stands one cycle after the read strobe, zero otherwise
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      if (RD && ADDR == DCR_OFS_DEVCAP)
      begin
         rdata_d = devcap;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;

   // Read path and strap checks
   chk_read_fixed_fields : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[11:0] == 12'h021)
      else $error("Fixed capability fields wrong");

   chk_read_payload_code : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R1]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[DCR_MPS_LSB +: 3] == DCR_MPS_RST)
      else $error("Payload size code wrong");

   chk_read_phantom_zero : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2]
      RD |=> RDATA[4:3] == 2'h0)
      else $error("Phantom field not zero");

   chk_read_tag_bit : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[5])
      else $error("Tag support bit not set");

   chk_read_latency_zero : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
      RD |=> RDATA[8:6] == 3'h0 && RDATA[11:9] == 3'h0)
      else $error("Latency fields not zero");

   chk_read_l0s_code : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[DCR_L0S_LSB +: 3] == DCR_L0S_RST)
      else $error("L0s latency code wrong");

   chk_read_l1_code : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[DCR_L1_LSB +: 3] == DCR_L1_RST)
      else $error("L1 latency code wrong");

   chk_read_button_bit : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[12] == $past(hp_q & fwd_q))
      else $error("Attention button bit wrong");

   chk_button_needs_fwd : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
      RD && ADDR == DCR_OFS_DEVCAP && !fwd_q |=> !RDATA[DCR_ATTN_BTN_BIT])
      else $error("Attention button set outside forward mode");

   chk_button_needs_strap : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
      RD && ADDR == DCR_OFS_DEVCAP && !hp_q |=> !RDATA[DCR_ATTN_BTN_BIT])
      else $error("Attention button set without hot-plug");

   chk_button_when_both : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
      RD && ADDR == DCR_OFS_DEVCAP && hp_q && fwd_q |=> RDATA[DCR_ATTN_BTN_BIT])
      else $error("Attention button missing with hot-plug on");

   chk_fwd_sample : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
      RST_B |=> fwd_q == $past(FORWARD_MODE))
      else $error("Bridge mode not sampled");

   chk_strap_sample : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
      RST_B |=> hp_q == $past(HOTPLUG_STRAP))
      else $error("Hot-plug strap not sampled");

   chk_read_indicator_bits : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[14:13] == {2{$past(hp_q)}})
      else $error("Indicator bits do not follow strap");

   chk_indicator_needs_strap : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
      RD && ADDR == DCR_OFS_DEVCAP && !hp_q |=> RDATA[14:13] == 2'h0)
      else $error("Indicator bits set without hot-plug");

   chk_indicator_when_strap : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R7]
      RD && ADDR == DCR_OFS_DEVCAP && hp_q |=> RDATA[14:13] == 2'h3)
      else $error("Indicator bits missing with hot-plug on");

   chk_read_reserved_zero : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8]
      RD |=> RDATA[17:15] == 3'h0 && RDATA[31:28] == 4'h0)
      else $error("Reserved bits not zero");

   chk_read_unmapped_zero : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8]
      RD && ADDR != DCR_OFS_DEVCAP |=> RDATA == 32'h0000_0000)
      else $error("Unmapped read not zero");

   chk_read_only_pulse : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8]
      !RD |=> RDATA == 32'h0000_0000)
      else $error("Read data outside read cycle");

   chk_read_reset_zero : assert property (@(posedge CORE_CLK) // [R8]
      !RST_B |=> RDATA == 32'h0000_0000)
      else $error("Read data not zero under reset");

   // Slot power checks
   chk_read_spl_fields : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9]
      RD && ADDR == DCR_OFS_DEVCAP && !SPL_VALID |=> RDATA[27:18] == {spl_scale, spl_value})
      else $error("Slot power fields misread");

   chk_read_spl_value : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[DCR_SPL_VAL_LSB +: 8] == $past(spl_value))
      else $error("Slot power value misread");

   chk_read_spl_scale : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
      RD && ADDR == DCR_OFS_DEVCAP |=> RDATA[DCR_SPL_SCL_LSB +: 2] == $past(spl_scale))
      else $error("Slot power scale misread");

   chk_write_ignored : assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9]
      WR && !SPL_VALID |=> $stable(spl_value) && $stable(spl_scale))
      else $error("Write changed read-only slot power fields");

   chk_spl_reset_value : assert property (@(posedge CORE_CLK) // [R9]
      !RST_B |=> spl_value == DCR_SPL_VAL_RST)
      else $error("Slot power value not cleared by reset");

   chk_spl_reset_scale : assert property (@(posedge CORE_CLK) // [R10]
      !RST_B |=> spl_scale == DCR_SPL_SCL_RST)
      else $error("Slot power scale not cleared by reset");
endmodule
`default_nettype wire

// ---- sim/dcr_spl_partner.sv ----
// Upstream port model that sends slot power limit messages.
// Assumes the bench calls send while the core clock runs.
`timescale 1ns/100ps
`default_nettype none
module dcr_spl_partner
(
   input  wire logic  clk,
   output logic       spl_valid,
   output logic [7:0] spl_value,
   output logic [1:0] spl_scale
);
   initial
   begin
      spl_valid = 1'b0;
      spl_value = 8'h3c;
      spl_scale = 2'h1;
   end
   // One message; hold keeps the strobe up for a back-to-back one
   task automatic send(input logic [7:0] v, input logic [1:0] s, input bit hold);
      @(posedge clk);
      spl_valid <= 1'b1;
      spl_value <= v;
      spl_scale <= s;
      if (!hold)
      begin
         @(posedge clk);
         spl_valid <= 1'b0;
         spl_value <= ~v;
         spl_scale <= ~s;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_dcr_devcap.sv ----
// Testbench for the device capability register.
// Assumes the read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module tb_dcr_devcap;
   import dcr_pkg::*;
   logic        CORE_CLK, RST_B, WR, RD, HOTPLUG_STRAP, FORWARD_MODE, SPL_VALID;
   logic [7:0]  ADDR, SPL_VALUE;
   logic [31:0] WDATA, RDATA;
   logic [1:0]  SPL_SCALE;
   int          n_fail = 0;
   int          n_tests = 0;
   dcr_devcap dcr_devcap_inst (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .HOTPLUG_STRAP(HOTPLUG_STRAP), .FORWARD_MODE(FORWARD_MODE),
      .SPL_VALID(SPL_VALID), .SPL_VALUE(SPL_VALUE), .SPL_SCALE(SPL_SCALE));
   dcr_spl_partner dcr_spl_partner_inst (.clk(CORE_CLK), .spl_valid(SPL_VALID), .spl_value(SPL_VALUE),
      .spl_scale(SPL_SCALE));
   initial
   begin
      CORE_CLK = 1'b0;
      forever #2 CORE_CLK = ~CORE_CLK;
   end
   function automatic logic [31:0] img(input logic s, f, input logic [7:0] v, input logic [1:0] c);
      img = {4'h0, c, v, 3'h0, s, s, s & f, 3'h0, 3'h0, 1'b1, 2'h0, 3'h1};
   endfunction
   task automatic cmp(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CORE_CLK);
      RD   <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 cmp("rdata", e, RDATA);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      WR    <= 1'b1;
      ADDR  <= a;
      WDATA <= d;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge CORE_CLK);
      n_fail++;
      finish_test;
   end
   initial
   begin
      RST_B = 1'b0;
      {WR, RD, HOTPLUG_STRAP, FORWARD_MODE} = 4'h0;
      ADDR  = 8'h00;
      WDATA = 32'h0;
      repeat (20) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      rd(8'hb4, img(1'b0, 1'b0, 8'h00, 2'h0));
      @(posedge CORE_CLK);
      #1 cmp("idle", 32'h0, RDATA);
      wr(8'hb4, 32'hffffffff);
      rd(8'hb4, 32'h00000021);
      rd(8'hb0, 32'h0);
      rd(8'hb8, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge CORE_CLK);
         HOTPLUG_STRAP <= i[1];
         FORWARD_MODE  <= i[0];
         @(posedge CORE_CLK);
         rd(8'hb4, img(i[1], i[0], 8'h00, 2'h0));
      end
      dcr_spl_partner_inst.send(8'hff, 2'h3, 1'b0);
      rd(8'hb4, img(1'b1, 1'b1, 8'hff, 2'h3));
      dcr_spl_partner_inst.send(8'h5a, 2'h1, 1'b1);
      dcr_spl_partner_inst.send(8'ha5, 2'h2, 1'b0);
      rd(8'hb4, img(1'b1, 1'b1, 8'ha5, 2'h2));
      @(posedge CORE_CLK);
      RST_B <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      rd(8'hb4, img(1'b1, 1'b1, 8'h00, 2'h0));
      finish_test;
   end
endmodule
`default_nettype wire
